//--- core/pir_route.sv
// pci interrupt routing: pins to request lines to interrupt numbers
`timescale 1ns/100ps
// Summary of operation
// - two modes: legacy sixteen, advanced twenty-four
// - eight request lines, each source drives one
// - numbers sixteen to twenty-three advanced only
// - advanced: lines A..H give sixteen..twenty-three
// - legacy: each line steered to allowed number
// - several lines may share one number
// - slot pins swizzled onto lines E..H
// - lan feeds line E, smbus feeds D
// - wired sources share one line interrupt
// - number two is the cascade input
// - serial and parallel defaults are reassignable
// - number nine reserved for smbus controller
// - disk numbers free when disks absent
// - usb assignments are dynamic, disk numbers fixed
module pir_route (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire pir_pkg::pir_mode_t mode_in,
  input wire logic [pir_pkg::NUM_LINES*pir_pkg::SEL_W-1:0] line_sel_in,
  input wire pir_pkg::pir_fixed_sel_t fixed_sel_in,
  input wire pir_pkg::pir_fixed_t fixed_in,
  input wire pir_pkg::pir_slot_t slot1_in,
  input wire pir_pkg::pir_slot_t slot2_in,
  input wire logic lan_int_a_n_in,
  input wire logic smbus_int_c_n_in,
  input wire logic usb_a_n_in,
  input wire logic usb_b_n_in,
  input wire logic usb_c_n_in,
  input wire logic usb_d_n_in,
  input wire logic secondary_pending_in,
  output logic [pir_pkg::NUM_ADV-1:0] irq_out,
  output logic [pir_pkg::NUM_LINES-1:0] line_pending_out,
  output pir_pkg::pir_mode_t mode_out
);
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // legal legacy target for a pci request line
  function automatic logic legal_sel(input logic [pir_pkg::SEL_W-1:0] s);
    legal_sel = pir_pkg::LEGACY_OK_MASK[s] && (s != pir_pkg::SEL_W'(pir_pkg::IRQ_SMBUS));
  endfunction

  // one-hot decode of a steering value
  function automatic logic [pir_pkg::NUM_LEGACY-1:0] dec(input logic [pir_pkg::SEL_W-1:0] s);
    dec = '0;
    dec[s] = 1'b1;
  endfunction

  // ---------------------------------------------------------------------------
  // wired request lines
  // ---------------------------------------------------------------------------
  logic [pir_pkg::NUM_LINES-1:0] line_n;
  // sources wired-and onto their line, low is asserted
  assign line_n[pir_pkg::LN_A] = usb_a_n_in;
  assign line_n[pir_pkg::LN_B] = usb_b_n_in;
  assign line_n[pir_pkg::LN_C] = usb_c_n_in;
  assign line_n[pir_pkg::LN_D] = usb_d_n_in & smbus_int_c_n_in;
  assign line_n[pir_pkg::LN_E] = lan_int_a_n_in & slot1_in.int_d_n
                                 & slot2_in.int_c_n;
  assign line_n[pir_pkg::LN_F] = slot1_in.int_a_n & slot2_in.int_b_n;
  assign line_n[pir_pkg::LN_G] = slot1_in.int_b_n & slot2_in.int_a_n;
  assign line_n[pir_pkg::LN_H] = slot1_in.int_c_n & slot2_in.int_d_n;

  // ---------------------------------------------------------------------------
  // pending state
  // ---------------------------------------------------------------------------
  logic [pir_pkg::NUM_LINES-1:0] pend_ff;
  logic [pir_pkg::NUM_LINES-1:0] nxt_pend;
  pir_pkg::pir_mode_t mode_ff;
  // level sensitive: pending while any source still holds low
  assign nxt_pend = ~line_n;

  // sample lines and mode
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_ff <= '0;
      mode_ff <= pir_pkg::PIR_MODE_LEGACY;
    end else if (clk_en_in) begin
      pend_ff <= nxt_pend;
      mode_ff <= mode_in;
    end
  end

  // ---------------------------------------------------------------------------
  // steering
  // ---------------------------------------------------------------------------
  logic adv_mode;
  logic [pir_pkg::NUM_LEGACY-1:0] legacy_from_lines;
  logic [pir_pkg::NUM_LEGACY-1:0] legacy_fixed;
  logic [pir_pkg::NUM_ADV-1:0] nxt_irq;
  logic [pir_pkg::NUM_ADV-1:0] irq_ff;
  assign adv_mode = (mode_ff == pir_pkg::PIR_MODE_ADV);

  // legacy steering, several lines may or together onto one number
  always_comb begin
    legacy_from_lines = '0;
    for (int i = 0; i < pir_pkg::NUM_LINES; i++) begin
      if (pend_ff[i] && legal_sel(line_sel_in[i*pir_pkg::SEL_W +: pir_pkg::SEL_W])) begin
        legacy_from_lines = legacy_from_lines
                            | dec(line_sel_in[i*pir_pkg::SEL_W +: pir_pkg::SEL_W]);
      end
    end
  end

  // fixed functions and their reassignable defaults
  always_comb begin
    legacy_fixed = '0;
    if (fixed_in.serial2) begin
      legacy_fixed = legacy_fixed | dec(fixed_sel_in.serial2);
    end
    if (fixed_in.serial1) begin
      legacy_fixed = legacy_fixed | dec(fixed_sel_in.serial1);
    end
    if (fixed_in.parallel1) begin
      legacy_fixed = legacy_fixed | dec(fixed_sel_in.parallel1);
    end
    if (fixed_in.disk0_present) begin
      legacy_fixed[pir_pkg::IRQ_DISK0] = fixed_in.disk0;
    end
    if (fixed_in.disk1_present) begin
      legacy_fixed[pir_pkg::IRQ_DISK1] = fixed_in.disk1;
    end
    legacy_fixed[pir_pkg::IRQ_CASCADE] = secondary_pending_in;
  end

  // merge per mode; upper numbers only exist in advanced mode
  always_comb begin
    nxt_irq = '0;
    nxt_irq[pir_pkg::NUM_LEGACY-1:0] = legacy_fixed;
    if (adv_mode) begin
      nxt_irq[pir_pkg::NUM_ADV-1:pir_pkg::IRQ_ADV_BASE] = pend_ff;
    end else begin
      nxt_irq[pir_pkg::NUM_LEGACY-1:0] = legacy_fixed | legacy_from_lines;
      nxt_irq[pir_pkg::IRQ_CASCADE] = secondary_pending_in;
    end
    // last, so no steered fixed function can land on nine
    nxt_irq[pir_pkg::IRQ_SMBUS] = 1'b0;
  end

  // registered outputs
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_ff <= '0;
    end else if (clk_en_in) begin
      irq_ff <= nxt_irq;
    end
  end

  assign irq_out = irq_ff;
  assign line_pending_out = pend_ff;
  assign mode_out = mode_ff;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_upper_legacy: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (clk_en_in && !adv_mode) |=> irq_out[pir_pkg::NUM_ADV-1:pir_pkg::IRQ_ADV_BASE] == '0)
    else $error("upper numbers active in legacy mode");
  a_adv_map: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (clk_en_in && adv_mode) |=> irq_out[pir_pkg::NUM_ADV-1:pir_pkg::IRQ_ADV_BASE] == $past(pend_ff))
    else $error("advanced line map wrong");
  a_line_level: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (reset_n_in && clk_en_in) |=> line_pending_out == ~$past(line_n))
    else $error("line pending not tracking level");
  a_lan_line_e: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (reset_n_in && clk_en_in && !lan_int_a_n_in) |=> line_pending_out[pir_pkg::LN_E])
    else $error("lan not on line e");
  a_slot1_a_f: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (reset_n_in && clk_en_in && !slot1_in.int_a_n) |=> line_pending_out[pir_pkg::LN_F])
    else $error("slot1 pin a not on line f");
  a_slot2_a_g: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (reset_n_in && clk_en_in && !slot2_in.int_a_n) |=> line_pending_out[pir_pkg::LN_G])
    else $error("slot2 pin a not on line g");
  a_smbus_nine: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ##1 !irq_out[pir_pkg::IRQ_SMBUS])
    else $error("number nine offered");
  a_cascade_two: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (reset_n_in && clk_en_in) |=> irq_out[pir_pkg::IRQ_CASCADE] == $past(secondary_pending_in))
    else $error("cascade mismatch");
  a_legacy_share: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (clk_en_in && !adv_mode && pend_ff[pir_pkg::LN_A]
     && legal_sel(line_sel_in[pir_pkg::SEL_W-1:0]))
    |=> irq_out[$past(line_sel_in[pir_pkg::SEL_W-1:0])])
    else $error("steered line a not delivered");
  c_adv_irq: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    adv_mode && irq_out[pir_pkg::IRQ_ADV_BASE]);
  c_shared: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !lan_int_a_n_in && !slot1_in.int_d_n);
  c_legacy_irq: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !adv_mode && |legacy_from_lines);
endmodule

//--- common/pir_pkg.sv
// package for the pci interrupt routing block
package pir_pkg;
  // ---------------------------------------------------------------------------
  // sizes and counts
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_LINES = 8;
  localparam int unsigned NUM_LEGACY = 16;
  localparam int unsigned NUM_ADV = 24;
  localparam int unsigned SEL_W = 4;
  // request line indices
  localparam int unsigned LN_A = 0;
  localparam int unsigned LN_B = 1;
  localparam int unsigned LN_C = 2;
  localparam int unsigned LN_D = 3;
  localparam int unsigned LN_E = 4;
  localparam int unsigned LN_F = 5;
  localparam int unsigned LN_G = 6;
  localparam int unsigned LN_H = 7;
  // fixed legacy interrupt numbers and the advanced base
  localparam int unsigned IRQ_CASCADE = 2;
  localparam int unsigned IRQ_SERIAL2 = 3;
  localparam int unsigned IRQ_SERIAL1 = 4;
  localparam int unsigned IRQ_PARALLEL1 = 7;
  localparam int unsigned IRQ_SMBUS = 9;
  localparam int unsigned IRQ_DISK0 = 14;
  localparam int unsigned IRQ_DISK1 = 15;
  localparam int unsigned IRQ_ADV_BASE = 16;
  // legal legacy steering targets: 3,4,5,6,7,9,10,11,12,14,15
  localparam logic [15:0] LEGACY_OK_MASK = 16'hDEF8;
  // steering value that disconnects a line
  localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PIR_MODE_LEGACY = 2'b00,
    PIR_MODE_ADV = 2'b01
  } pir_mode_t;

  // per-slot active-low pins
  typedef struct packed {
    logic int_d_n;
    logic int_c_n;
    logic int_b_n;
    logic int_a_n;
  } pir_slot_t;

  // fixed-function requests, active high
  typedef struct packed {
    logic serial1;
    logic serial2;
    logic parallel1;
    logic disk0;
    logic disk1;
    logic disk0_present;
    logic disk1_present;
  } pir_fixed_t;

  // configurable legacy destinations
  typedef struct packed {
    logic [SEL_W-1:0] serial1;
    logic [SEL_W-1:0] serial2;
    logic [SEL_W-1:0] parallel1;
  } pir_fixed_sel_t;
endpackage

//--- bench/pir_cards.sv
// partner model: cards and onboard functions on open-drain request pins
`timescale 1ns/100ps
module pir_cards (
  input wire logic [13:0] req_in,
  output pir_pkg::pir_slot_t slot1_out,
  output pir_pkg::pir_slot_t slot2_out,
  output logic lan_n_out,
  output logic smbus_n_out,
  output logic [3:0] usb_n_out
);
  // card interrupt k pulls pin k low, released pins rise on the pull-up
  assign slot1_out = ~req_in[3:0];
  assign slot2_out = ~req_in[7:4];
  // onboard functions, one pin each
  assign lan_n_out = ~req_in[8];
  assign smbus_n_out = ~req_in[9];
  assign usb_n_out = ~req_in[13:10];
endmodule

//--- bench/test_pir_route.sv
// self-checking bench for the pci interrupt routing block
`timescale 1ns/100ps
module test_pir_route;
  typedef struct packed {
    pir_pkg::pir_mode_t md;
    logic [31:0] sel;
    logic [13:0] src;
    logic [7:0] pend;
    logic [23:0] irq;
  } pir_row_t;
  localparam pir_pkg::pir_mode_t ADV = pir_pkg::PIR_MODE_ADV;
  localparam pir_pkg::pir_mode_t LEG = pir_pkg::PIR_MODE_LEGACY;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  pir_pkg::pir_mode_t mode = LEG;
  logic [31:0] sel = 32'h0;
  pir_pkg::pir_fixed_sel_t fsel = 12'h0;
  pir_pkg::pir_fixed_t fix = 7'h0;
  logic [13:0] src = 14'h0;
  logic sec = 1'b0;
  pir_pkg::pir_slot_t s1;
  pir_pkg::pir_slot_t s2;
  logic lan_n;
  logic smb_n;
  logic [3:0] usb_n;
  logic [23:0] irq;
  logic [7:0] pend;
  pir_pkg::pir_mode_t mode_o;
  int err_total = 0;
  int cmp_count = 0;
  pir_row_t rows [13];

  // free-running system clock
  always #5 clk = ~clk;

  pir_cards cards_u (.req_in(src), .slot1_out(s1), .slot2_out(s2), .lan_n_out(lan_n),
    .smbus_n_out(smb_n), .usb_n_out(usb_n));
  pir_route dut_u (.sys_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(clk_en), .mode_in(mode),
    .line_sel_in(sel), .fixed_sel_in(fsel), .fixed_in(fix), .slot1_in(s1), .slot2_in(s2),
    .lan_int_a_n_in(lan_n), .smbus_int_c_n_in(smb_n), .usb_a_n_in(usb_n[0]),
    .usb_b_n_in(usb_n[1]), .usb_c_n_in(usb_n[2]), .usb_d_n_in(usb_n[3]),
    .secondary_pending_in(sec), .irq_out(irq), .line_pending_out(pend), .mode_out(mode_o));

  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk_irq(input logic [23:0] e);
    cmp_count++;
    if (irq !== e) begin
      err_total++;
      $display("CHECK FAILED irq_out exp %h got %h", e, irq);
    end
  endtask

  task automatic chk_line(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  // fixed-function inputs, then settle
  task automatic fx(input logic [11:0] fs, input logic [6:0] f, input logic s);
    @(posedge clk);
    fsel <= fs;
    fix <= f;
    sec <= s;
    step(3);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    final_report();
  end

  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    rows = '{
      '{ADV, 32'h0, 14'h0001, 8'h20, 24'h200000},
      '{ADV, 32'h0, 14'h0030, 8'h60, 24'h600000},
      '{ADV, 32'h0, 14'h0100, 8'h10, 24'h100000},
      '{ADV, 32'h0, 14'h0200, 8'h08, 24'h080000},
      '{ADV, 32'h0, 14'h3C00, 8'h0F, 24'h0F0000},
      '{ADV, 32'h0, 14'h0086, 8'hC0, 24'hC00000},
      '{ADV, 32'h0, 14'h0048, 8'h10, 24'h100000},
      '{ADV, 32'h0, 14'h0008, 8'h10, 24'h100000},
      '{LEG, 32'hCBA76543, 14'h3FFF, 8'hFF, 24'h001CF8},
      '{LEG, 32'hCB976543, 14'h0001, 8'h20, 24'h0},
      '{LEG, 32'h000000EE, 14'h0C00, 8'h03, 24'h004000},
      '{LEG, 32'h00F00000, 14'h0001, 8'h20, 24'h008000},
      '{LEG, 32'h00200000, 14'h3FFF, 8'hFF, 24'h0}};
    repeat (5) @(posedge clk);
    #1;
    chk_irq(24'h0);
    chk_line("line_pending_out", 8'h0, pend);
    @(posedge clk);
    rst_n <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk);
      mode <= rows[i].md;
      sel <= rows[i].sel;
      src <= rows[i].src;
      step(4);
      chk_line("line_pending_out", rows[i].pend, pend);
      chk_irq(rows[i].irq);
      chk_line("mode_out", {6'h0, rows[i].md}, {6'h0, mode_o});
    end
    $display("test table done");
    // walk: pin to line in one cycle, line to number in one more
    @(posedge clk);
    mode <= ADV;
    src <= 14'h0001;
    step(1);
    chk_line("line_pending_out", 8'h20, pend);
    chk_irq(24'h0);
    step(1);
    chk_irq(24'h200000);
    @(posedge clk);
    src <= 14'h0;
    step(1);
    chk_line("line_pending_out", 8'h0, pend);
    $display("test walk done");
    // fixed-function numbers in legacy mode
    @(posedge clk);
    mode <= LEG;
    fx(12'h437, 7'h40, 1'b0);
    chk_irq(24'h000010);
    fx(12'h537, 7'h40, 1'b0);
    chk_irq(24'h000020);
    fx(12'h537, 7'h30, 1'b0);
    chk_irq(24'h000088);
    fx(12'h537, 7'h0C, 1'b0);
    chk_irq(24'h0);
    fx(12'h537, 7'h0F, 1'b0);
    chk_irq(24'h00C000);
    fx(12'h937, 7'h40, 1'b0);
    chk_irq(24'h0);
    fx(12'h537, 7'h00, 1'b1);
    chk_irq(24'h000004);
    $display("test fixed done");
    // clock enable low freezes pending and numbers
    @(posedge clk);
    clk_en <= 1'b0;
    src <= 14'h0001;
    step(3);
    chk_line("line_pending_out", 8'h0, pend);
    chk_irq(24'h000004);
    @(posedge clk);
    clk_en <= 1'b1;
    step(2);
    chk_line("line_pending_out", 8'h20, pend);
    $display("test clock enable done");
    // reset in mid-run with every line pending
    @(posedge clk);
    mode <= ADV;
    src <= 14'h3FFF;
    step(4);
    @(posedge clk);
    rst_n <= 1'b0;
    step(1);
    chk_irq(24'h0);
    chk_line("line_pending_out", 8'h0, pend);
    chk_line("mode_out", 8'h0, {6'h0, mode_o});
    @(posedge clk);
    rst_n <= 1'b1;
    step(4);
    chk_line("line_pending_out", 8'hFF, pend);
    $display("test mid reset done");
    final_report();
  end
endmodule
